// file: src/gcd_pkg.sv
/*
 Shared constants of the gain, chop and detect register bank: register
 indices, field positions, masks, reset values and counter widths.
 Assumes a 32-bit AHB-Lite bus where each register takes one word.
*/
package gcd_pkg;
   localparam int ADDR_W = 32;
   localparam int IDX_W = 8;
   localparam logic [IDX_W-1:0] IDX_LOWER_GAINS = 8'h04;
   localparam logic [IDX_W-1:0] IDX_UPPER_GAINS = 8'h05;
   localparam logic [IDX_W-1:0] IDX_CONF = 8'h06;
   localparam logic [IDX_W-1:0] IDX_THR_UPPER = 8'h07;
   localparam logic [IDX_W-1:0] IDX_THR_LOWER = 8'h08;
   localparam logic [IDX_W-1:0] IDX_STATUS = 8'h20;

   localparam logic [15:0] GAIN_RESET = 16'h0000;
   localparam logic [15:0] GAIN_MASK = 16'h7777;
   localparam logic [15:0] CONF_RESET = 16'h0600;
   localparam logic [15:0] CONF_MASK = 16'h1fff;
   localparam logic [15:0] THR_RESET = 16'h0000;
   localparam logic [15:0] THR_LOWER_MASK = 16'hff00;

   localparam int NUM_CH = 8;
   localparam int CH_PER_REG = 4;
   localparam int CODE_W = 3;
   localparam int CH_STRIDE = 4;
   localparam int DLY_LSB = 9;
   localparam int DLY_W = 4;
   localparam int CHOP_EN_BIT = 8;
   localparam int POLICY_BIT = 7;
   localparam int EXC_LSB = 4;
   localparam int LEN_LSB = 1;
   localparam int DET_EN_BIT = 0;
   localparam int THR_W = 24;

   localparam int ST_HIT_BIT = 0;
   localparam int ST_SETTLED_BIT = 1;
   localparam int ST_MEAS_BIT = 2;

   localparam int DLY_CNT_W = 17;
   localparam int LEN_W = 12;
   localparam int EXC_CNT_W = 8;

   function automatic logic [LEN_W-1:0] gcd_meas_len(
      input logic [CODE_W-1:0] code);
      unique case (code)
         3'h0: gcd_meas_len = 12'h080;
         3'h1: gcd_meas_len = 12'h100;
         3'h2: gcd_meas_len = 12'h200;
         3'h3: gcd_meas_len = 12'h300;
         3'h4: gcd_meas_len = 12'h500;
         3'h5: gcd_meas_len = 12'h700;
         3'h6: gcd_meas_len = 12'ha00;
         3'h7: gcd_meas_len = 12'he00;
      endcase
   endfunction : gcd_meas_len
endpackage : gcd_pkg

// file: src/gcd_chop_settle.sv
/*
 Global-chop settling counter: counts modulator clock periods after a
 chop restart and flags when the programmed wait has elapsed.
 Assumes the modulator clock arrives on a pin, slower than hclk / 2.
*/
`timescale 1ns/1ps
module gcd_chop_settle
   import gcd_pkg::*;
#(
   parameter int CNT_W = DLY_CNT_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic chop_enable,
   input wire logic [DLY_W-1:0] delay_code,
   input wire logic restart,
   input wire logic mod_clk_pin,
   output logic settled
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic [CNT_W-1:0] cnt;
      logic done;
   } gcd_chop_t;

   gcd_chop_t r;
   gcd_chop_t n;
   logic [CNT_W-1:0] target;

   always_comb begin
      target = {{(CNT_W-1){1'b0}}, 1'b1} << (32'(delay_code) + 1);
      n = r;
      n.s1 = mod_clk_pin;
      n.s2 = r.s1;
      n.s3 = r.s2;
      if (!chop_enable || restart) begin
         n.cnt = '0;
         n.done = 1'b0;
      end else if (!r.done && r.s2 && !r.s3) begin
         n.cnt = r.cnt + 1'b1;
         if (n.cnt == target) begin
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign settled = r.done;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_settle_count: assert property ($rose(r.done) |-> r.cnt == target)
      else $error("Chop settle flagged at wrong count.");
   chk_chop_off: assert property (!chop_enable |=> !r.done)
      else $error("Chop settled while chop is disabled.");
endmodule : gcd_chop_settle

// file: src/gcd_detect.sv
/*
 Current-detect trigger: compares each channel sample with the signed
 threshold, applies the any/all policy per conversion period, counts
 exceedances and pulses a detection within each measurement window.
 Assumes samples arrive channel 0 first, channel 7 closing a period.
*/
`timescale 1ns/1ps
module gcd_detect
   import gcd_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic enable,
   input wire logic policy_all,
   input wire logic [CODE_W-1:0] exc_code,
   input wire logic [CODE_W-1:0] len_code,
   input wire logic [THR_W-1:0] threshold,
   input wire logic sample_valid,
   input wire logic [CODE_W-1:0] sample_ch,
   input wire logic [THR_W-1:0] sample_data,
   output logic detect_pulse,
   output logic measuring
);
   typedef struct packed {
      logic [NUM_CH-1:0] mask;
      logic [LEN_W-1:0] per;
      logic [EXC_CNT_W-1:0] exc;
      logic pulse;
      logic meas;
   } gcd_det_t;

   gcd_det_t r;
   gcd_det_t n;
   logic [NUM_CH-1:0] mask_new;
   logic [EXC_CNT_W-1:0] need;
   logic [EXC_CNT_W-1:0] exc_new;
   logic [LEN_W-1:0] len;
   logic over;
   logic hit;

   always_comb begin
      over = $signed(sample_data) > $signed(threshold);
      mask_new = r.mask | (NUM_CH'(over) << sample_ch);
      hit = policy_all ? (&mask_new) : (|mask_new);
      need = {{(EXC_CNT_W-1){1'b0}}, 1'b1} << exc_code;
      len = gcd_meas_len(len_code);
      exc_new = r.exc + EXC_CNT_W'(hit);
      n = r;
      n.pulse = 1'b0;
      n.meas = enable;
      if (!enable) begin
         n.mask = '0;
         n.per = '0;
         n.exc = '0;
      end else if (sample_valid) begin
         n.mask = mask_new;
         if (sample_ch == CODE_W'(NUM_CH - 1)) begin
            n.mask = '0;
            if (hit && exc_new >= need) begin
               n.pulse = 1'b1;
               n.exc = '0;
               n.per = '0;
            end else if (r.per >= len - 1'b1) begin
               n.exc = '0;
               n.per = '0;
            end else begin
               n.exc = exc_new;
               n.per = r.per + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign detect_pulse = r.pulse;
   assign measuring = r.meas;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_window_bound: assert property (r.per < len)
      else $error("Measurement period count left its window.");
   chk_pulse_need: assert property (
      r.pulse |-> $past(exc_new) >= $past(need))
      else $error("Detection fired before enough exceedances.");
   chk_pulse_enabled: assert property (r.pulse |-> $past(enable))
      else $error("Detection fired while detect mode was off.");
endmodule : gcd_detect

// file: src/gcd_regs.sv
/*
 Gain, global-chop and current-detect register bank with an AHB-Lite
 slave. Drives per-channel amplifier codes and chop/detect settings.
 Assumes a single AHB-Lite master, whole-word single transfers, and a
 modulator clock pin plus sample stream from the converter core.
*/
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Lower gain register holds channels 0 to 3.
// - Gain code n means gain two to n.
// - Upper gain register at 5h, resets 0000h.
// - Upper register holds channels 4 to 7.
// - Config at 06h, reset 0600h, top reserved.
// - Chop delay waits two to code+1 periods.
// - Bit 8 turns global chop on.
// - Bit 7 picks any or all channels.
// - Bits 6:4 set needed exceedance count.
// - Bits 3:1 set measurement window length.
// - Samples compare against 24-bit signed threshold.
module gcd_regs
   import gcd_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic mod_clk_pin,
   input wire logic sample_valid,
   input wire logic [CODE_W-1:0] sample_ch,
   input wire logic [THR_W-1:0] sample_data,
   output logic [NUM_CH*CODE_W-1:0] amp_codes,
   output logic chop_enable,
   output logic [DLY_W-1:0] chop_settle_delay,
   output logic chop_settled,
   output logic detect_mode_enable,
   output logic detect_hit
);
   typedef struct packed {
      logic [15:0] lo_gain;
      logic [15:0] hi_gain;
      logic [15:0] conf;
      logic [15:0] thr_hi;
      logic [15:0] thr_lo;
      logic hit;
      logic wr_pend;
      logic [IDX_W-1:0] wr_idx;
      logic [31:0] rdata;
      logic ready;
      logic restart;
   } gcd_bank_t;

   gcd_bank_t r;
   gcd_bank_t n;
   logic [IDX_W:0] dec;
   logic take;
   logic det_pulse;
   logic settled;
   logic measuring;

   // Returns a valid flag above the word index of an aligned address.
   function automatic logic [IDX_W:0] idx_of(input logic [ADDR_W-1:0] a);
      idx_of = {(a[ADDR_W-1:IDX_W+2] == '0) && (a[1:0] == 2'b00),
         a[IDX_W+1:2]};
   endfunction : idx_of

   // Read value of one register; unmapped words read zero.
   function automatic logic [31:0] read_word(input gcd_bank_t s,
      input logic [IDX_W-1:0] idx, input logic st, input logic ms);
      read_word = 32'h0000_0000;
      unique case (idx)
         IDX_LOWER_GAINS: read_word[15:0] = s.lo_gain;
         IDX_UPPER_GAINS: read_word[15:0] = s.hi_gain;
         IDX_CONF: read_word[15:0] = s.conf;
         IDX_THR_UPPER: read_word[15:0] = s.thr_hi;
         IDX_THR_LOWER: read_word[15:0] = s.thr_lo;
         IDX_STATUS: begin
            read_word[ST_HIT_BIT] = s.hit;
            read_word[ST_SETTLED_BIT] = st;
            read_word[ST_MEAS_BIT] = ms;
         end
         default: read_word = 32'h0000_0000;
      endcase
   endfunction : read_word

   always_comb begin
      dec = idx_of(haddr);
      take = hsel && htrans[1] && hready;
      n = r;
      n.ready = 1'b1;
      n.restart = 1'b0;
      if (r.wr_pend) begin
         unique case (r.wr_idx)
            IDX_LOWER_GAINS: n.lo_gain = hwdata[15:0] & GAIN_MASK;
            IDX_UPPER_GAINS: n.hi_gain = hwdata[15:0] & GAIN_MASK;
            IDX_CONF: begin
               n.conf = hwdata[15:0] & CONF_MASK;
               n.restart = 1'b1;
            end
            IDX_THR_UPPER: n.thr_hi = hwdata[15:0];
            IDX_THR_LOWER: n.thr_lo = hwdata[15:0] & THR_LOWER_MASK;
            IDX_STATUS: begin
               if (hwdata[ST_HIT_BIT]) begin
                  n.hit = 1'b0;
               end
            end
            default: n.restart = 1'b0;
         endcase
      end
      if (det_pulse) begin
         n.hit = 1'b1;
      end
      n.wr_pend = take && hwrite && dec[IDX_W];
      n.wr_idx = dec[IDX_W-1:0];
      n.rdata = 32'h0000_0000;
      if (take && !hwrite && dec[IDX_W]) begin
         n.rdata = read_word(n, dec[IDX_W-1:0], settled, measuring);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= '0;
         r.lo_gain <= GAIN_RESET;
         r.hi_gain <= GAIN_RESET;
         r.conf <= CONF_RESET;
         r.thr_hi <= THR_RESET;
         r.thr_lo <= THR_RESET;
         r.ready <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // Code n on each channel selects an amplifier gain of 2**n.
   for (genvar g = 0; g < CH_PER_REG; g++) begin : g_codes
      assign amp_codes[g*CODE_W +: CODE_W] =
         r.lo_gain[g*CH_STRIDE +: CODE_W];
      assign amp_codes[(g+CH_PER_REG)*CODE_W +: CODE_W] =
         r.hi_gain[g*CH_STRIDE +: CODE_W];
   end

   assign hrdata = r.rdata;
   assign hreadyout = r.ready;
   assign hresp = 1'b0;
   assign chop_enable = r.conf[CHOP_EN_BIT];
   assign chop_settle_delay = r.conf[DLY_LSB +: DLY_W];
   assign detect_mode_enable = r.conf[DET_EN_BIT];
   assign detect_hit = r.hit;
   assign chop_settled = settled;

   gcd_chop_settle #(
      .CNT_W(DLY_CNT_W)
   ) u_chop (
      .hclk(hclk),
      .hresetn(hresetn),
      .chop_enable(r.conf[CHOP_EN_BIT]),
      .delay_code(r.conf[DLY_LSB +: DLY_W]),
      .restart(r.restart),
      .mod_clk_pin(mod_clk_pin),
      .settled(settled)
   );

   gcd_detect u_det (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(r.conf[DET_EN_BIT]),
      .policy_all(r.conf[POLICY_BIT]),
      .exc_code(r.conf[EXC_LSB +: CODE_W]),
      .len_code(r.conf[LEN_LSB +: CODE_W]),
      .threshold({r.thr_hi, r.thr_lo[15:8]}),
      .sample_valid(sample_valid),
      .sample_ch(sample_ch),
      .sample_data(sample_data),
      .detect_pulse(det_pulse),
      .measuring(measuring)
   );

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_wr_addr(logic [IDX_W-1:0] idx);
      hsel && htrans[1] && hready && hwrite
         && haddr == {22'h00_0000, idx, 2'b00};
   endsequence

   sequence s_rd_addr(logic [IDX_W-1:0] idx);
      hsel && htrans[1] && hready && !hwrite && !r.wr_pend
         && haddr == {22'h00_0000, idx, 2'b00};
   endsequence

   chk_gain_reserved: assert property (
      ((r.lo_gain | r.hi_gain) & ~GAIN_MASK) == 16'h0000)
      else $error("Reserved gain bits are not zero.");
   chk_upper_write: assert property (
      s_wr_addr(IDX_UPPER_GAINS) ##1 1'b1
      |=> r.hi_gain == ($past(hwdata[15:0]) & GAIN_MASK))
      else $error("Upper gain register did not take write data.");
   chk_lower_write: assert property (
      s_wr_addr(IDX_LOWER_GAINS) ##1 1'b1
      |=> amp_codes[2:0] == $past(hwdata[2:0]))
      else $error("Channel 0 code does not follow lower gain write.");
   chk_lower_read: assert property (
      s_rd_addr(IDX_LOWER_GAINS) |=> hrdata == {16'h0000, $past(r.lo_gain)})
      else $error("Lower gain read returned wrong value.");
   chk_conf_reserved: assert property (r.conf[15:13] == 3'b000)
      else $error("Reserved config bits are not zero.");
   chk_hit_sticky: assert property (det_pulse |=> r.hit [*2])
      else $error("Detection flag lost after a detection.");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("Slave answered with wait or error.");
   chk_chop_restart: assert property (
      s_wr_addr(IDX_CONF) ##1 1'b1 |=> r.restart ##1 !settled)
      else $error("Config write did not restart chop settling.");
endmodule : gcd_regs

// file: testbench/gcd_regs_bench.sv
/*
 Self-checking bench for the gain, chop and detect register bank.
 Assumes the bench is the only AHB-Lite master, with zero-wait answers.
*/
`timescale 1ns/1ps
module gcd_regs_bench
   import gcd_pkg::*;
;
   localparam logic [31:0] A_LO = {22'h0, IDX_LOWER_GAINS, 2'b00};
   localparam logic [31:0] A_UP = {22'h0, IDX_UPPER_GAINS, 2'b00};
   localparam logic [31:0] A_CF = {22'h0, IDX_CONF, 2'b00};
   localparam logic [31:0] A_TU = {22'h0, IDX_THR_UPPER, 2'b00};
   localparam logic [31:0] A_TL = {22'h0, IDX_THR_LOWER, 2'b00};
   localparam logic [31:0] A_ST = {22'h0, IDX_STATUS, 2'b00};
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, sample_ch;
   logic mod_clk_pin, sample_valid, chop_enable, chop_settled;
   logic detect_mode_enable, detect_hit;
   logic [23:0] sample_data, amp_codes, exp_codes;
   logic [3:0] chop_settle_delay;
   int failures, comparisons;

   assign hready = hreadyout;

   gcd_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .mod_clk_pin(mod_clk_pin),
      .sample_valid(sample_valid), .sample_ch(sample_ch),
      .sample_data(sample_data), .amp_codes(amp_codes),
      .chop_enable(chop_enable), .chop_settle_delay(chop_settle_delay),
      .chop_settled(chop_settled), .detect_mode_enable(detect_mode_enable),
      .detect_hit(detect_hit));

   always #12.5 hclk = ~hclk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : check

   task automatic give_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   task automatic xfer(input logic [31:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0000_0000);
   endtask : xfer

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] rd;
      xfer(a, 1'b1, d, rd);
   endtask : wr

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      xfer(a, 1'b0, 32'h0000_0000, rd);
      check(rd, exp);
   endtask : rd_chk

   task automatic test_reset_values();
      rd_chk(A_LO, 32'h0000_0000);
      rd_chk(A_UP, 32'h0000_0000);
      rd_chk(A_CF, 32'h0000_0600);
      check({8'h00, amp_codes}, 32'h0000_0000);
      check({28'h0, chop_settle_delay}, 32'h0000_0003);
      check({31'h0, chop_enable}, 32'h0000_0000);
      check({31'h0, detect_mode_enable}, 32'h0000_0000);
   endtask : test_reset_values

   task automatic test_gains();
      for (int i = 0; i < NUM_CH; i++) begin
         exp_codes[3*i+:3] = 3'(i);
      end
      wr(A_LO, 32'h0000_3210);
      wr(A_UP, 32'h0000_7654);
      rd_chk(A_LO, 32'h0000_3210);
      rd_chk(A_UP, 32'h0000_7654);
      check({8'h00, amp_codes}, {8'h00, exp_codes});
      wr(A_UP, 32'h0000_7777);
      rd_chk(A_UP, 32'h0000_7777);
      @(posedge hclk);
      check({20'h0, amp_codes[23:12]}, 32'h0000_0fff);
      check({20'h0, amp_codes[11:0]}, {20'h0, exp_codes[11:0]});
      wr(A_LO, 32'h0000_0000);
      @(posedge hclk);
      check({20'h0, amp_codes[11:0]}, 32'h0000_0000);
      rd_chk(32'h0000_0040, 32'h0000_0000);
   endtask : test_gains

   task automatic test_config();
      wr(A_CF, 32'h0000_1fff);
      rd_chk(A_CF, 32'h0000_1fff);
      check({28'h0, chop_settle_delay}, 32'h0000_000f);
      check({31'h0, chop_enable}, 32'h0000_0001);
      check({31'h0, detect_mode_enable}, 32'h0000_0001);
      wr(A_CF, 32'h0000_0000);
      rd_chk(A_CF, 32'h0000_0000);
      check({31'h0, chop_enable}, 32'h0000_0000);
   endtask : test_config

   task automatic mod_ticks(input int n);
      repeat (n) begin
         mod_clk_pin <= 1'b1;
         repeat (3) @(posedge hclk);
         mod_clk_pin <= 1'b0;
         repeat (3) @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
   endtask : mod_ticks

   task automatic test_chop(input logic [3:0] code);
      int need;
      need = 2 ** (int'(code) + 1);
      wr(A_CF, {19'h0, code, 9'h100});
      mod_ticks(need - 1);
      check({31'h0, chop_settled}, 32'h0000_0000);
      mod_ticks(1);
      check({31'h0, chop_settled}, 32'h0000_0001);
      rd_chk(A_ST, 32'h0000_0002);
   endtask : test_chop

   task automatic send_period(input logic [7:0] over, input logic exp);
      for (int ch = 0; ch < NUM_CH; ch++) begin
         sample_valid <= 1'b1;
         sample_ch <= 3'(ch);
         sample_data <= over[ch] ? 24'h00_0101 : 24'h00_0100;
         @(posedge hclk);
      end
      sample_valid <= 1'b0;
      repeat (4) @(posedge hclk);
      check({31'h0, detect_hit}, {31'h0, exp});
   endtask : send_period

   task automatic test_detect();
      wr(A_TL, 32'h0000_ab00);
      rd_chk(A_TL, 32'h0000_ab00);
      wr(A_TU, 32'h0000_0001);
      rd_chk(A_TU, 32'h0000_0001);
      wr(A_TL, 32'h0000_0000);
      wr(A_CF, 32'h0000_0001);
      send_period(8'h00, 1'b0);
      send_period(8'h01, 1'b1);
      wr(A_ST, 32'h0000_0001);
      wr(A_CF, 32'h0000_0081);
      send_period(8'h7f, 1'b0);
      send_period(8'hff, 1'b1);
      wr(A_ST, 32'h0000_0001);
      rd_chk(A_ST, 32'h0000_0004);
      wr(A_CF, 32'h0000_0011);
      send_period(8'h80, 1'b0);
      send_period(8'h80, 1'b1);
   endtask : test_detect

   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      mod_clk_pin = 1'b0;
      sample_valid = 1'b0;
      sample_ch = 3'h0;
      sample_data = 24'h00_0000;
      failures = 0;
      comparisons = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      test_reset_values();
      test_gains();
      test_config();
      test_chop(4'h0);
      test_chop(4'h1);
      test_chop(4'h3);
      wr(A_CF, 32'h0000_0000);
      test_detect();
      give_verdict();
   end

   initial begin
      #(25 * 20000);
      failures++;
      give_verdict();
   end
endmodule : gcd_regs_bench
